// ### verilog/ocl_pkg.sv
// Purpose: shared constants of the overload current limiter
// Assumes: 32-bit AHB-Lite register bus, 50 MHz clock
// Notes: currents in mA, durations in ms, energy in mA*ms internally
package ocl_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_PEAK = 8'h00; // peak current, mA
	localparam logic [7:0] OFS_RATED = 8'h04; // rated current, mA
	localparam logic [7:0] OFS_DURATION = 8'h08; // peak duration, ms
	localparam logic [7:0] OFS_THRESHOLD = 8'h0C; // limit, mAs
	localparam logic [7:0] OFS_ACCUM = 8'h10; // accumulated value, mAs
	localparam logic [7:0] OFS_IMPOSED = 8'h14; // imposed current, mA
	localparam logic [7:0] OFS_STATE = 8'h18; // 0 inactive, 1 active
	localparam logic [7:0] OFS_SUBMODE = 8'h1C; // drive submode word
	localparam logic [7:0] OFS_CONTROL = 8'h20; // function enable
	// field positions
	localparam int SUBMODE_CLOSED_BIT = 0; // closed loop flag
	localparam int CONTROL_ENABLE_BIT = 0; // limiter enable
	// reset values
	localparam logic [31:0] PEAK_RESET = 32'h0000_0000;
	localparam logic [31:0] RATED_RESET = 32'h0000_0000;
	localparam logic [31:0] DURATION_RESET = 32'h0000_0000;
	localparam logic [31:0] SUBMODE_RESET = 32'h0000_0000;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] STATE_INACTIVE = 32'h0000_0000;
	localparam logic [31:0] STATE_ACTIVE = 32'h0000_0001;
	// timing: one accumulation step per millisecond
	localparam int CLK_PERIOD_NS = 20;
	localparam int STEP_PERIOD_NS = 1000000;
	localparam int STEP_CYCLES = STEP_PERIOD_NS / CLK_PERIOD_NS;
	// mA*ms per mAs
	localparam logic [63:0] MS_PER_S = 64'h0000_0000_0000_03E8;
	// ahb encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ### verilog/ocl_limiter.sv
// Purpose: thermal overload current limiter with AHB-Lite registers
// Assumes: demand current comes from logic on the same clock
// Notes: single clock, zero wait state slave, always OKAY
`timescale 1ns/1ps

// Overview of operation
// - limiter works only in closed loop
// - active needs peak above rated, nonzero duration
// - limit derived from rated, peak, duration
// - below limit allow peak, then clamp rated
// - threshold readable in milliampere-seconds
// - accumulate continuously, compare against threshold
// - imposed current limit is readable
// - status reads 0 inactive, 1 active
// - higher current accumulates faster
// - closed loop is submode bit 0
// - enabled in open loop clamps to rated
module ocl_limiter #(
	parameter int STEP_CYCLES = ocl_pkg::STEP_CYCLES // ms step length
) (
	input wire logic ref_clk_in, // 50 MHz clock
	input wire logic rst_in, // synchronous, active high
	input wire logic hsel_in, // ahb slave select
	input wire logic [31:0] haddr_in, // ahb byte address
	input wire logic [1:0] htrans_in, // ahb transfer type
	input wire logic hwrite_in, // ahb write flag
	input wire logic [2:0] hsize_in, // ahb size
	input wire logic [31:0] hwdata_in, // ahb write data
	input wire logic hready_in, // ahb bus ready
	output logic [31:0] hrdata_out, // ahb read data
	output logic hreadyout_out, // ahb slave ready
	output logic hresp_out, // ahb response
	input wire logic [31:0] current_demand_in, // requested current, mA
	output logic [31:0] current_limit_out, // imposed limit, mA
	output logic [31:0] current_command_out, // clamped current, mA
	output logic limiter_active_out // limiter status
);
	// configuration registers
	logic [31:0] peak_current_limit_q; // mA
	logic [31:0] rated_current_setting_q; // mA
	logic [31:0] peak_duration_setting_q; // ms
	logic [31:0] submode_q; // drive submode word
	logic [31:0] control_q; // function enable word
	// limiter state
	logic [63:0] accum_q; // accumulated value, mA*ms
	logic over_q; // limit reached, clamp engaged
	logic active_q; // status flag
	logic [31:0] imposed_current_q; // limit currently imposed
	logic [31:0] step_cnt_q; // ms divider
	logic step_q; // one-cycle ms enable
	// bus data phase capture
	logic wr_pend_q; // write data phase pending
	logic [7:0] wr_ofs_q; // write offset
	logic [31:0] rdata_q; // read data register
	// combinational terms
	logic closed_loop; // submode says closed loop
	logic enabled; // software enable
	logic cond_ok; // activation conditions
	logic [63:0] threshold_raw; // limit in mA*ms
	logic [31:0] threshold_mas; // limit in mAs
	logic [31:0] accum_mas; // accumulation in mAs
	logic [31:0] excess; // current above rated
	logic [31:0] deficit; // current below rated
	logic addr_phase; // valid address phase this cycle
	logic [31:0] rd_mux; // read selection

	assign closed_loop = submode_q[ocl_pkg::SUBMODE_CLOSED_BIT];
	assign enabled = control_q[ocl_pkg::CONTROL_ENABLE_BIT];
	// peak above rated and a duration given, in closed loop
	assign cond_ok = enabled && closed_loop
		&& (peak_current_limit_q > rated_current_setting_q)
		&& (peak_duration_setting_q != 32'h0000_0000);
	// excess over rated times allowed time gives the energy budget
	assign threshold_raw = (64'(peak_current_limit_q)
		- 64'(rated_current_setting_q))
		* 64'(peak_duration_setting_q);
	// constant divide; ok at 50 MHz for a slowly changing value
	assign threshold_mas = 32'(threshold_raw / ocl_pkg::MS_PER_S);
	assign accum_mas = 32'(accum_q / ocl_pkg::MS_PER_S);
	// step size grows with the current, so higher loads trip sooner
	assign excess = (current_demand_in > rated_current_setting_q)
		? current_demand_in - rated_current_setting_q
		: 32'h0000_0000;
	assign deficit = (current_demand_in < rated_current_setting_q)
		? rated_current_setting_q - current_demand_in
		: 32'h0000_0000;

	// ms step divider
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			step_cnt_q <= 32'h0000_0000;
			step_q <= 1'b0;
		end else if (step_cnt_q == 32'(STEP_CYCLES - 1)) begin
			step_cnt_q <= 32'h0000_0000;
			step_q <= 1'b1;
		end else begin
			step_cnt_q <= step_cnt_q + 32'h0000_0001;
			step_q <= 1'b0;
		end
	end

	// accumulation: add excess, cool down by deficit, floor at zero
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			accum_q <= 64'h0000_0000_0000_0000;
		end else if (!cond_ok) begin
			// inactive: no history is kept
			accum_q <= 64'h0000_0000_0000_0000;
		end else if (step_q) begin
			if (excess != 32'h0000_0000) begin
				accum_q <= accum_q + 64'(excess);
			end else if (accum_q > 64'(deficit)) begin
				accum_q <= accum_q - 64'(deficit);
			end else begin
				accum_q <= 64'h0000_0000_0000_0000;
			end
		end
	end

	// clamp engages at the limit and releases once fully cooled
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			over_q <= 1'b0;
		end else if (!cond_ok) begin
			over_q <= 1'b0;
		end else if (accum_q >= threshold_raw) begin
			over_q <= 1'b1;
		end else if (accum_q == 64'h0000_0000_0000_0000) begin
			over_q <= 1'b0;
		end
	end

	// status and imposed limit
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			active_q <= 1'b0;
			imposed_current_q <= ocl_pkg::PEAK_RESET;
		end else begin
			active_q <= cond_ok;
			if (enabled && !closed_loop) begin
				// open loop safety: never above rated
				imposed_current_q <= rated_current_setting_q;
			end else if (cond_ok && over_q) begin
				imposed_current_q <= rated_current_setting_q;
			end else begin
				imposed_current_q <= peak_current_limit_q;
			end
		end
	end

	assign current_limit_out = imposed_current_q;
	assign limiter_active_out = active_q;
	// commanded current passes through the imposed clamp
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			current_command_out <= 32'h0000_0000;
		end else if (current_demand_in > imposed_current_q) begin
			current_command_out <= imposed_current_q;
		end else begin
			current_command_out <= current_demand_in;
		end
	end

	// ahb: address phase accepted when selected and bus ready
	assign addr_phase = hsel_in && hready_in
		&& (htrans_in == ocl_pkg::HTRANS_NONSEQ
		|| htrans_in == 2'h3);
	assign hreadyout_out = 1'b1; // zero wait states
	assign hresp_out = 1'b0; // always OKAY
	assign hrdata_out = rdata_q;

	// read selection, unmapped reads as zero
	always_comb begin
		unique case (haddr_in[7:0])
			ocl_pkg::OFS_PEAK: rd_mux = peak_current_limit_q;
			ocl_pkg::OFS_RATED: rd_mux = rated_current_setting_q;
			ocl_pkg::OFS_DURATION: rd_mux = peak_duration_setting_q;
			ocl_pkg::OFS_THRESHOLD: rd_mux = threshold_mas;
			ocl_pkg::OFS_ACCUM: rd_mux = accum_mas;
			ocl_pkg::OFS_IMPOSED: rd_mux = imposed_current_q;
			ocl_pkg::OFS_STATE: rd_mux = active_q
				? ocl_pkg::STATE_ACTIVE
				: ocl_pkg::STATE_INACTIVE;
			ocl_pkg::OFS_SUBMODE: rd_mux = submode_q;
			ocl_pkg::OFS_CONTROL: rd_mux = control_q;
			default: rd_mux = 32'h0000_0000;
		endcase
		if (haddr_in[31:8] != 24'h00_0000) begin
			rd_mux = 32'h0000_0000;
		end
	end

	// read data latched at the address phase edge
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (addr_phase && !hwrite_in) begin
			rdata_q <= rd_mux;
		end
	end

	// remember a write until its data phase
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			wr_pend_q <= 1'b0;
			wr_ofs_q <= 8'h00;
		end else if (hready_in) begin
			wr_pend_q <= addr_phase && hwrite_in
				&& haddr_in[31:8] == 24'h00_0000;
			wr_ofs_q <= haddr_in[7:0];
		end
	end

	// configuration writes; read-only offsets ignore writes
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			peak_current_limit_q <= ocl_pkg::PEAK_RESET;
			rated_current_setting_q <= ocl_pkg::RATED_RESET;
			peak_duration_setting_q <= ocl_pkg::DURATION_RESET;
			submode_q <= ocl_pkg::SUBMODE_RESET;
			control_q <= ocl_pkg::CONTROL_RESET;
		end else if (wr_pend_q) begin
			unique case (wr_ofs_q)
				ocl_pkg::OFS_PEAK: peak_current_limit_q <= hwdata_in;
				ocl_pkg::OFS_RATED: rated_current_setting_q <= hwdata_in;
				ocl_pkg::OFS_DURATION: peak_duration_setting_q <= hwdata_in;
				ocl_pkg::OFS_SUBMODE: submode_q <= hwdata_in;
				ocl_pkg::OFS_CONTROL: control_q <= hwdata_in;
				default: ; // read-only or unmapped
			endcase
		end
	end

	// checks
	status_closed_loop_a: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		!closed_loop |=> !active_q)
		else $error("status active outside closed loop");
	status_conditions_a: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(peak_current_limit_q <= rated_current_setting_q
		|| peak_duration_setting_q == 32'h0000_0000) |=> !active_q)
		else $error("status active without valid settings");
	clamp_at_limit_a: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(cond_ok && accum_q >= threshold_raw) ##1 cond_ok
		|=> imposed_current_q == $past(rated_current_setting_q))
		else $error("limit reached but rated clamp missing");
	peak_below_a: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(cond_ok && !over_q && $stable(peak_current_limit_q))
		|=> imposed_current_q == $past(peak_current_limit_q))
		else $error("peak not allowed below limit");
	accum_grows_a: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(cond_ok && step_q && excess != 32'h0000_0000)
		##1 cond_ok
		|-> accum_q == $past(accum_q) + 64'($past(excess)))
		else $error("accumulation step wrong");
	state_report_a: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		addr_phase && !hwrite_in && haddr_in == 32'(ocl_pkg::OFS_STATE)
		|=> rdata_q == {31'h0000_0000, $past(active_q)})
		else $error("status read value wrong");
	open_loop_rated_a: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(enabled && !closed_loop) ##1 (enabled && !closed_loop)
		|-> imposed_current_q == $past(rated_current_setting_q))
		else $error("open loop limit not rated");
	reset_clear_a: assert property (@(posedge ref_clk_in)
		rst_in |=> accum_q == 64'h0000_0000_0000_0000
		&& !active_q)
		else $error("reset did not clear limiter");
	step_period_a: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		step_q |=> !step_q)
		else $error("step enable longer than one cycle");
	cmd_clamped_a: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		current_command_out <= $past(imposed_current_q)
		|| current_command_out == $past(current_demand_in))
		else $error("command exceeds imposed limit");
	cover_activate_c: cover property (@(posedge ref_clk_in)
		disable iff (rst_in) !active_q ##1 active_q);
	cover_trip_c: cover property (@(posedge ref_clk_in)
		disable iff (rst_in) !over_q ##1 over_q);
	cover_release_c: cover property (@(posedge ref_clk_in)
		disable iff (rst_in) over_q ##1 !over_q);
	cover_open_loop_c: cover property (@(posedge ref_clk_in)
		disable iff (rst_in) enabled && !closed_loop);
endmodule

// ### dv/ocl_limiter_bench.sv
// Purpose: self-checking bench for the overload current limiter
// Assumes: zero wait AHB-Lite slave, short step length for simulation
// Notes: bus master moves signals just after rising edges only
`timescale 1ns/1ps
module ocl_limiter_bench;
	localparam int SC = 10; // short step so a run stays brief
	logic ref_clk_in = 1'b0; // 50 MHz bench clock
	logic rst_in = 1'b1; // held for ten cycles at start
	logic hsel = 1'b0; // bus select
	logic hwrite = 1'b0; // bus direction
	logic [1:0] htrans = 2'h0; // idle until a transfer
	logic [31:0] haddr = 32'h0; // byte address
	logic [31:0] hwdata = 32'h0; // write data
	logic [31:0] dem = 32'h0; // demanded current, mA
	logic [31:0] rdata, lim, cmd, v; // design outputs and read value
	logic act, hrdy, hresp; // status and bus answer
	int err_total = 0;
	int tests_run = 0;
	int n1, n2; // cycles until the clamp
	// free running clock
	always #10 ref_clk_in = ~ref_clk_in;
	ocl_limiter #(.STEP_CYCLES(SC)) dut_u (.ref_clk_in(ref_clk_in),
		.rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(ocl_pkg::HSIZE_WORD), .hwdata_in(hwdata),
		.hready_in(hrdy), .hrdata_out(rdata), .hreadyout_out(hrdy),
		.hresp_out(hresp), .current_demand_in(dem),
		.current_limit_out(lim), .current_command_out(cmd),
		.limiter_active_out(act));
	// one compare for every value kind; case equality catches unknowns
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// next edge where hready is high, bounded
	task automatic edge_rdy();
		int n;
		n = 0;
		@(posedge ref_clk_in);
		while (hrdy !== 1'b1 && n < 100) begin
			n++;
			@(posedge ref_clk_in);
		end
	endtask
	// single word transfer; leading edge leaves an idle gap
	task automatic ahb(bit wr, logic [7:0] a, logic [31:0] wd);
		@(posedge ref_clk_in);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= ocl_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		edge_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		edge_rdy();
		v = rdata;
	endtask
	task automatic rdc(string nm, logic [7:0] a, logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(nm, exp, v);
	endtask
	task automatic set_dem(logic [31:0] d);
		@(posedge ref_clk_in);
		dem <= d;
	endtask
	// sample on falling edges so the outputs have settled
	task automatic wait_lim(logic [31:0] e, output int n);
		n = 0;
		while (lim !== e && n < 2000) begin
			@(negedge ref_clk_in);
			n++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// hang guard, far beyond the expected run of under a thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		err_total++;
		report_and_stop();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		// every register plus one unmapped word reads zero
		for (int i = 0; i <= 9; i++) begin
			rdc("reset_reg", 8'(i * 4), 32'h0);
		end
		chk("state_pin", 32'h0, {31'h0, act});
		// bus answer: always ready, always OKAY
		@(negedge ref_clk_in);
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("hready", 32'h1, {31'h0, hrdy});
		ahb(1'b1, ocl_pkg::OFS_PEAK, 32'h0000_07D0);
		ahb(1'b1, ocl_pkg::OFS_RATED, 32'h0000_03E8);
		ahb(1'b1, ocl_pkg::OFS_DURATION, 32'h0000_000A);
		ahb(1'b1, ocl_pkg::OFS_THRESHOLD, 32'h0000_FFFF);
		rdc("peak", ocl_pkg::OFS_PEAK, 32'h0000_07D0);
		// (2000-1000)*10 mA*ms is 10 mAs; the write was ignored
		rdc("thresh", ocl_pkg::OFS_THRESHOLD, 32'h0000_000A);
		rdc("state_off", ocl_pkg::OFS_STATE, 32'h0);
		chk("lim_off", 32'h0000_07D0, lim);
		ahb(1'b1, ocl_pkg::OFS_SUBMODE, 32'h0000_0001);
		ahb(1'b1, ocl_pkg::OFS_CONTROL, 32'h0000_0001);
		rdc("state_on", ocl_pkg::OFS_STATE, 32'h1);
		// peak equal to rated, then zero duration, keep it off
		ahb(1'b1, ocl_pkg::OFS_PEAK, 32'h0000_03E8);
		rdc("st_eq", ocl_pkg::OFS_STATE, 32'h0);
		ahb(1'b1, ocl_pkg::OFS_PEAK, 32'h0000_07D0);
		ahb(1'b1, ocl_pkg::OFS_DURATION, 32'h0);
		rdc("st_dur0", ocl_pkg::OFS_STATE, 32'h0);
		ahb(1'b1, ocl_pkg::OFS_DURATION, 32'h0000_000A);
		// status follows the settings one cycle later; look once settled
		repeat (2) @(negedge ref_clk_in);
		chk("act_on", 32'h1, {31'h0, act});
		// full peak: allowed at first, clamped after ten steps
		set_dem(32'h0000_07D0);
		repeat (3) @(negedge ref_clk_in);
		chk("cmd_peak", 32'h0000_07D0, cmd);
		wait_lim(32'h0000_03E8, n1);
		chk("n1_ok", 32'h1, {31'h0, n1 >= 9 * SC && n1 <= 11 * SC});
		@(negedge ref_clk_in);
		chk("cmd_clamp", 32'h0000_03E8, cmd);
		ahb(1'b0, ocl_pkg::OFS_ACCUM, 32'h0);
		chk("acc_hi", 32'h1, {31'h0, v >= 32'hA});
		// cooling at zero demand releases the clamp at zero
		set_dem(32'h0);
		wait_lim(32'h0000_07D0, n2);
		chk("release", 32'h0000_07D0, lim);
		rdc("acc_zero", ocl_pkg::OFS_ACCUM, 32'h0);
		// enabled in open loop clamps to rated and reads inactive
		ahb(1'b1, ocl_pkg::OFS_SUBMODE, 32'h0);
		repeat (3) @(negedge ref_clk_in);
		chk("open_lim", 32'h0000_03E8, lim);
		chk("open_act", 32'h0, {31'h0, act});
		ahb(1'b1, ocl_pkg::OFS_SUBMODE, 32'h0000_0001);
		wait_lim(32'h0000_07D0, n2);
		// smaller excess takes twice as long as full peak
		set_dem(32'h0000_05DC);
		repeat (3) @(negedge ref_clk_in);
		chk("cmd_pass", 32'h0000_05DC, cmd);
		wait_lim(32'h0000_03E8, n2);
		chk("n2_ok", 32'h1, {31'h0, n2 >= 19 * SC && n2 <= 21 * SC});
		chk("faster", 32'h1, {31'h0, n1 < n2});
		// reset in mid-run clears everything
		@(posedge ref_clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(negedge ref_clk_in);
		chk("rst_act", 32'h0, {31'h0, act});
		chk("rst_lim", 32'h0, lim);
		rdc("rst_acc", ocl_pkg::OFS_ACCUM, 32'h0);
		rdc("rst_peak", ocl_pkg::OFS_PEAK, 32'h0);
		report_and_stop();
	end
endmodule
